// ==== hdl/mps_pkg.sv ====
// package: constants, enums and carriers for the midi program selector
package mps_pkg;
   typedef enum logic [1:0] {RX_OFF, RX_ONE, RX_OMNI} mps_rx_t;
   typedef enum logic [1:0] {PGM_OFF, PGM_ON, PGM_MAP, PGM_CHAIN} mps_pgm_t;
   typedef struct packed {
      logic sysex_rx;
      logic auto_tx;
      mps_pgm_t pgm;
      logic [3:0] tx_ch;
      logic [3:0] rx_ch;
      mps_rx_t rx;
   } mps_cfg_t;
   typedef struct packed {
      logic [5:0] bank;
      logic [5:0] eff;
   } mps_slot_t;
   typedef struct packed {
      logic [6:0] addr;
      logic [6:0] val;
   } mps_param_t;
   // controls: 0 knob, 1 pedal, 2 switch one, 3 switch two
   typedef struct packed {
      logic [3:0] move;
      logic [3:0][6:0] val;
   } mps_ctl_t;
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_UNIT = 8'h04;
   localparam logic [7:0] ADDR_ASGN = 8'h08;
   localparam logic [7:0] ADDR_CARD = 8'h0C;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_MAP = 8'h14;
   localparam logic [7:0] ADDR_CHAIN = 8'h18;
   localparam logic [7:0] ADDR_PARAM = 8'h1C;
   localparam mps_cfg_t CFG_RST = '{1'b0, 1'b0, PGM_ON, 4'h0, 4'h0, RX_ONE};
   localparam logic [6:0] OWN_UNIT_RST = 7'h00;
   localparam logic [6:0] UNIT_ALL = 7'h7F;
   localparam logic [6:0] EFF_COUNT = 7'h32;
   localparam logic [5:0] EFF_LAST = 6'h31;
   localparam logic [5:0] BANK_PGM_LAST = 6'h05;
   localparam logic [5:0] BANK_REG = 6'h06;
   localparam logic [5:0] BANK_CARD0 = 6'h0C;
   localparam logic [3:0] CHAIN_COUNT = 4'hA;
   localparam logic [5:0] CARD_BANKS_64 = 6'h02;
   localparam logic [5:0] CARD_BANKS_256 = 6'h0B;
   localparam logic [5:0] CARD_BANKS_512 = 6'h17;
   localparam logic [5:0] CARD_BANKS_1M = 6'h2F;
   localparam logic [3:0] ST_CC = 4'hB;
   localparam logic [3:0] ST_PC = 4'hC;
   localparam logic [7:0] SX_START = 8'hF0;
   localparam logic [7:0] SX_END = 8'hF7;
   localparam logic [7:0] RT_FIRST = 8'hF8;
   localparam logic [6:0] CC_BANK = 7'h00;
   localparam logic [2:0] SX_LEN = 3'h4;
endpackage

// ==== hdl/mps_top.sv ====
// midi program selector: parser, program logic, transmit and register slave
// What this block does
// - receive off, one channel, or omni
// - mode off drops program and bank messages
// - mode on: programs 0-49 pick effects
// - mode on: programs 50-127 ignored
// - mode on: step moves within current bank
// - bank select picks program, register, card
// - card size limits valid card banks
// - map mode translates through 128-entry tables
// - map mode steps walk the table
// - chain mode loads chains, steps walk them
// - automation sends panel changes as sysex
// - sysex updates parameters, never operating state
// - sysex accepted only enabled, unit own or broadcast
// - default destination all, own unit 0
// - assigned local controls send controllers
// - incoming matching controller acts as control
// - pedal sharing knob number drives knob
`timescale 1ns/10ps
`default_nettype none
module mps_top
   import mps_pkg::*;
#(
   parameter logic [6:0] MFR_ID = 7'h55  // arbitrary value
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   output logic [7:0] tx_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire mps_pkg::mps_ctl_t ctl_in,
   input wire logic pgm_up,
   input wire logic pgm_dn,
   input wire logic panel_chg,
   input wire mps_pkg::mps_param_t panel_param,
   output logic load_valid,
   output mps_pkg::mps_slot_t load_slot,
   output logic knob_drv_valid,
   output logic [6:0] knob_drv_val,
   output logic [3:0] ctl_act,
   output logic [6:0] ctl_act_val,
   output logic param_valid,
   output mps_pkg::mps_param_t param_out
);
   import mps_pkg::*;
   typedef enum {P_IDLE, P_D1, P_D2, P_SX} mps_ps_t;
   mps_cfg_t cfg_r;
   logic [6:0] own_unit_r, dest_unit_r;
   logic [3:0][6:0] asgn_r;
   logic [2:0] card_r;
   logic map_sel_r;
   logic [11:0] map_mem [256];
   logic [11:0] chain_mem [128];
   mps_ps_t ps_r;
   logic [3:0] st_r;
   logic ok_r, pc_ev_r, cc_ev_r, sx_ev_r, tx_drop_r;
   logic [6:0] d1_r, pc_num_r, cc_num_r, cc_val_r;
   logic [6:0] sx_b_r [4];
   logic [2:0] sx_cnt_r;
   mps_slot_t cur_r;
   logic [6:0] map_idx_r;
   logic [3:0] chain_r;
   logic [2:0] chain_pos_r;
   logic [7:0] tx_buf_r [6];
   logic [2:0] tx_cnt_r;
   logic chan_ok, sx_ok, bank_ok, wr_go, rd_go;
   logic [5:0] card_banks;
   logic [31:0] wmask;
   mps_slot_t map_hit, pc_chain_slot;

   // channel filter decided at the status byte, kept for running status
   assign chan_ok = (cfg_r.rx == RX_OMNI) ||
      (cfg_r.rx == RX_ONE && rx_byte[3:0] == cfg_r.rx_ch);
   // broadcast destination is also taken, otherwise master default misses
   assign sx_ok = cfg_r.sysex_rx && sx_cnt_r == SX_LEN && sx_b_r[0] == MFR_ID
      && (sx_b_r[1] == own_unit_r || sx_b_r[1] == UNIT_ALL);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ps_r <= P_IDLE;
         st_r <= 4'h0;
         ok_r <= 1'b0;
         d1_r <= 7'h00;
         pc_num_r <= 7'h00;
         cc_num_r <= 7'h00;
         cc_val_r <= 7'h00;
         sx_cnt_r <= 3'h0;
         pc_ev_r <= 1'b0;
         cc_ev_r <= 1'b0;
         sx_ev_r <= 1'b0;
      end
      else
      begin
         pc_ev_r <= 1'b0;
         cc_ev_r <= 1'b0;
         sx_ev_r <= 1'b0;
         if (rx_valid && rx_byte[7] && rx_byte < RT_FIRST)
         begin
            if (rx_byte == SX_END && ps_r == P_SX)
               sx_ev_r <= sx_ok;
            if (rx_byte == SX_START)
            begin
               ps_r <= P_SX;
               sx_cnt_r <= 3'h0;
            end
            else if (rx_byte[7:4] == ST_CC || rx_byte[7:4] == ST_PC)
            begin
               st_r <= rx_byte[7:4];
               ok_r <= chan_ok;
               ps_r <= P_D1;
            end
            else
               ps_r <= P_IDLE;
         end
         else if (rx_valid && !rx_byte[7])
         begin
            case (ps_r)
               P_D1:
                  if (st_r == ST_PC)
                  begin
                     pc_ev_r <= ok_r;
                     pc_num_r <= rx_byte[6:0];
                  end
                  else
                  begin
                     d1_r <= rx_byte[6:0];
                     ps_r <= P_D2;
                  end
               P_D2:
               begin
                  cc_ev_r <= ok_r;
                  cc_num_r <= d1_r;
                  cc_val_r <= rx_byte[6:0];
                  ps_r <= P_D1;
               end
               P_SX:
                  if (sx_cnt_r != 3'h5)
                     sx_cnt_r <= sx_cnt_r + 3'h1;
               default:
                  ps_r <= ps_r;
            endcase
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (rx_valid && ps_r == P_SX && !rx_byte[7] && sx_cnt_r < SX_LEN)
         sx_b_r[sx_cnt_r[1:0]] <= rx_byte[6:0];
   end

   always_comb
   begin
      case (card_r)
         3'h1: card_banks = CARD_BANKS_64;
         3'h2: card_banks = CARD_BANKS_256;
         3'h3: card_banks = CARD_BANKS_512;
         3'h4: card_banks = CARD_BANKS_1M;
         default: card_banks = 6'h00;
      endcase
   end
   // 7-11 reserved and card banks beyond the card are ignored
   assign bank_ok = cc_val_r[6:0] <= {1'b0, BANK_REG} ||
      (cc_val_r >= {1'b0, BANK_CARD0} &&
       cc_val_r < {1'b0, BANK_CARD0 + card_banks});
   assign map_hit = map_mem[{map_sel_r, pc_num_r}];
   assign pc_chain_slot = chain_mem[{map_hit.eff[3:0], 3'h0}];

   // program state; sysex parameter updates never touch it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cur_r <= '0;
         map_idx_r <= 7'h00;
         chain_r <= 4'h0;
         chain_pos_r <= 3'h0;
         load_valid <= 1'b0;
         load_slot <= '0;
      end
      else
      begin
         load_valid <= 1'b0;
         if (cc_ev_r && cc_num_r == CC_BANK && cfg_r.pgm != PGM_OFF
             && bank_ok)
            cur_r.bank <= cc_val_r[5:0];
         if (pc_ev_r)
         begin
            case (cfg_r.pgm)
               PGM_ON:
                  if (pc_num_r < EFF_COUNT)
                  begin
                     cur_r.eff <= pc_num_r[5:0];
                     load_slot <= '{cur_r.bank, pc_num_r[5:0]};
                     load_valid <= 1'b1;
                  end
               PGM_MAP:
               begin
                  map_idx_r <= pc_num_r;
                  cur_r <= map_hit;
                  load_slot <= map_hit;
                  load_valid <= 1'b1;
               end
               PGM_CHAIN:
                  if (map_hit.eff[3:0] < CHAIN_COUNT)
                  begin
                     chain_r <= map_hit.eff[3:0];
                     chain_pos_r <= 3'h0;
                     load_slot <= pc_chain_slot;
                     load_valid <= 1'b1;
                  end
               default:
                  load_valid <= 1'b0;
            endcase
         end
         else if (pgm_up ^ pgm_dn)
         begin
            load_valid <= 1'b1;
            case (cfg_r.pgm)
               PGM_MAP:
               begin
                  map_idx_r <= pgm_up ? map_idx_r + 7'h1 : map_idx_r - 7'h1;
                  load_slot <= map_mem[{map_sel_r,
                     pgm_up ? map_idx_r + 7'h1 : map_idx_r - 7'h1}];
               end
               PGM_CHAIN:
               begin
                  chain_pos_r <= pgm_up ? chain_pos_r + 3'h1
                                        : chain_pos_r - 3'h1;
                  load_slot <= chain_mem[{chain_r, pgm_up ?
                     chain_pos_r + 3'h1 : chain_pos_r - 3'h1}];
               end
               default:
               begin
                  // steps stay inside the bank, wrapping at the ends
                  cur_r.eff <= pgm_up ? (cur_r.eff == EFF_LAST ? 6'h00 :
                     cur_r.eff + 6'h01) : (cur_r.eff == 6'h00 ? EFF_LAST :
                     cur_r.eff - 6'h01);
                  load_slot <= '{cur_r.bank, pgm_up ?
                     (cur_r.eff == EFF_LAST ? 6'h00 : cur_r.eff + 6'h01) :
                     (cur_r.eff == 6'h00 ? EFF_LAST : cur_r.eff - 6'h01)};
               end
            endcase
         end
      end
   end

   // incoming controllers, local knob and pedal sharing the knob number
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctl_act <= 4'h0;
         ctl_act_val <= 7'h00;
         knob_drv_valid <= 1'b0;
         knob_drv_val <= 7'h00;
         param_valid <= 1'b0;
         param_out <= '0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
            ctl_act[i] <= cc_ev_r && asgn_r[i] != 7'h00 &&
               cc_num_r == asgn_r[i];
         ctl_act_val <= cc_val_r;
         knob_drv_valid <= (cc_ev_r && asgn_r[0] != 7'h00 &&
            cc_num_r == asgn_r[0]) || ctl_in.move[0] ||
            (ctl_in.move[1] && asgn_r[1] != 7'h00 &&
             asgn_r[1] == asgn_r[0]);
         knob_drv_val <= ctl_in.move[0] ? ctl_in.val[0] :
            ctl_in.move[1] ? ctl_in.val[1] : cc_val_r;
         param_valid <= sx_ev_r;
         if (sx_ev_r)
            param_out <= '{sx_b_r[2], sx_b_r[3]};
      end
   end

   // transmit: one message at a time, events arriving while busy are lost
   logic [3:0] cc_go;
   assign cc_go = ctl_in.move & {asgn_r[3] != 7'h00, asgn_r[2] != 7'h00,
      asgn_r[1] != 7'h00, asgn_r[0] != 7'h00};
   assign tx_valid = tx_cnt_r != 3'h0;
   assign tx_byte = tx_buf_r[0];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx_cnt_r <= 3'h0;
      else if (tx_valid)
      begin
         if (tx_ready)
         begin
            for (int i = 0; i < 5; i++)
               tx_buf_r[i] <= tx_buf_r[i + 1];
            tx_cnt_r <= tx_cnt_r - 3'h1;
         end
      end
      else if (cc_go != 4'h0)
      begin
         tx_cnt_r <= 3'h3;
         tx_buf_r[0] <= {ST_CC, cfg_r.tx_ch};
         for (int i = 3; i >= 0; i--)
            if (cc_go[i])
            begin
               tx_buf_r[1] <= {1'b0, asgn_r[i]};
               tx_buf_r[2] <= {1'b0, ctl_in.val[i]};
            end
      end
      else if (panel_chg && cfg_r.auto_tx)
      begin
         tx_cnt_r <= 3'h6;
         tx_buf_r[0] <= SX_START;
         tx_buf_r[1] <= {1'b0, MFR_ID};
         tx_buf_r[2] <= {1'b0, dest_unit_r};
         tx_buf_r[3] <= {1'b0, panel_param.addr};
         tx_buf_r[4] <= {1'b0, panel_param.val};
         tx_buf_r[5] <= SX_END;
      end
   end

   // register slave: write taken when address and data are both offered
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_go;
   always_comb
      for (int i = 0; i < 4; i++)
         wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_r <= CFG_RST;
         own_unit_r <= OWN_UNIT_RST;
         dest_unit_r <= UNIT_ALL;
         asgn_r <= '0;
         card_r <= 3'h0;
         map_sel_r <= 1'b0;
         tx_drop_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // a drop in the clearing cycle stays set
         if (wr_go && s_axi_awaddr == ADDR_STAT)
            tx_drop_r <= 1'b0;
         if (tx_valid && (cc_go != 4'h0 || (panel_chg && cfg_r.auto_tx)))
            tx_drop_r <= 1'b1;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (s_axi_awaddr)
               ADDR_CFG: cfg_r <= mps_cfg_t'((32'(cfg_r) & ~wmask) |
                  (s_axi_wdata & wmask));
               ADDR_UNIT:
               begin
                  if (s_axi_wstrb[0]) own_unit_r <= s_axi_wdata[6:0];
                  if (s_axi_wstrb[1]) dest_unit_r <= s_axi_wdata[14:8];
               end
               ADDR_ASGN:
                  for (int i = 0; i < 4; i++)
                     if (s_axi_wstrb[i])
                        asgn_r[i] <= s_axi_wdata[i*8 +: 7];
               ADDR_CARD:
                  if (s_axi_wstrb[0])
                  begin
                     card_r <= s_axi_wdata[2:0];
                     map_sel_r <= s_axi_wdata[3];
                  end
               ADDR_STAT, ADDR_MAP, ADDR_CHAIN: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (wr_go && s_axi_awaddr == ADDR_MAP)
         map_mem[s_axi_wdata[7:0]] <= s_axi_wdata[19:8];
      if (wr_go && s_axi_awaddr == ADDR_CHAIN &&
          s_axi_wdata[3:0] < CHAIN_COUNT)
         chain_mem[{s_axi_wdata[3:0], s_axi_wdata[6:4]}] <= s_axi_wdata[19:8];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr)
            ADDR_CFG: s_axi_rdata <= 32'(cfg_r);
            ADDR_UNIT: s_axi_rdata <= {17'h0, dest_unit_r, 1'b0, own_unit_r};
            ADDR_ASGN: s_axi_rdata <= {1'b0, asgn_r[3], 1'b0, asgn_r[2],
               1'b0, asgn_r[1], 1'b0, asgn_r[0]};
            ADDR_CARD: s_axi_rdata <= {28'h0, map_sel_r, card_r};
            ADDR_STAT: s_axi_rdata <= {5'h0, tx_drop_r, chain_pos_r,
               chain_r, map_idx_r, cur_r};
            ADDR_PARAM: s_axi_rdata <= {18'h0, param_out};
            ADDR_MAP, ADDR_CHAIN: s_axi_rdata <= 32'h0;
            default:
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_pc_taken;
      pc_ev_r && !pgm_up && !pgm_dn;
   endsequence
   sequence s_status_off;
      rx_valid && rx_byte == 8'hC0 && cfg_r.rx == RX_OFF;
   endsequence
   a_pc_off_drop: assert property (
      s_pc_taken and cfg_r.pgm == PGM_OFF |=> !load_valid)
      else $error("program loaded in off mode");
   a_pc_on_load: assert property (
      s_pc_taken and cfg_r.pgm == PGM_ON and pc_num_r < EFF_COUNT
      |=> load_valid && {1'b0, load_slot.eff} == $past(pc_num_r))
      else $error("no load");
   a_pc_high_drop: assert property (
      s_pc_taken and cfg_r.pgm == PGM_ON and pc_num_r >= EFF_COUNT
      |=> !load_valid && $stable(cur_r))
      else $error("high program acted");
   a_bank_reserved: assert property (
      cc_ev_r && cc_num_r == CC_BANK && cc_val_r > 7'h06 && cc_val_r < 7'h0C
      |=> $stable(cur_r.bank))
      else $error("reserved bank taken");
   a_rx_off_quiet: assert property (
      s_status_off ##[1:2] rx_valid && !rx_byte[7] |=> !pc_ev_r)
      else $error("off receive acted");
   a_sysex_gate: assert property (
      !$past(cfg_r.sysex_rx) |-> !sx_ev_r)
      else $error("sysex accepted while disabled");
   a_unit_reset: assert property (
      $rose(aresetn) |-> own_unit_r == 7'h00 && dest_unit_r == 7'h7F)
      else $error("unit defaults wrong");
   a_knob_cc_tx: assert property (
      ctl_in.move == 4'h1 && asgn_r[0] != 0 && !tx_valid
      |=> tx_valid && tx_byte == {4'hB, $past(cfg_r.tx_ch)})
      else $error("no controller sent");
   a_auto_tx: assert property (
      panel_chg && cfg_r.auto_tx && !tx_valid && cc_go == 4'h0
      |=> tx_valid && tx_byte == 8'hF0)
      else $error("no automation message");
   a_cc_acts: assert property (
      cc_ev_r && asgn_r[0] != 0 && cc_num_r == asgn_r[0] |=> ctl_act[0])
      else $error("incoming controller ignored");
   a_pedal_knob: assert property (
      ctl_in.move == 4'h2 && asgn_r[1] != 0 && asgn_r[1] == asgn_r[0]
      |=> knob_drv_valid && knob_drv_val == $past(ctl_in.val[1]))
      else $error("pedal does not drive knob");
endmodule // mps_top
`default_nettype wire

// ==== bench/mps_far.sv ====
// far-side midi model: sends bytes into the block and sinks its output
`timescale 1ns/10ps
`default_nettype none
module mps_far (
   input wire logic aclk,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [7:0] rq[$];
   logic [3:0] stall_r = 4'h5;
   initial
   begin
      rx_byte = 8'h00;
      rx_valid = 1'b0;
   end
   // stalls on a rotating pattern so every byte after a message's first must be held
   always @(posedge aclk)
   begin
      stall_r <= {stall_r[2:0], stall_r[3]};
      if (tx_valid && tx_ready)
         rq.push_back(tx_byte);
   end
   assign tx_ready = stall_r[0];
   // released line shows the inverse of the last byte, never a stale copy
   task automatic send(input logic [7:0] b);
      @(posedge aclk);
      rx_byte <= b;
      rx_valid <= 1'b1;
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_byte <= ~b;
   endtask
endmodule // mps_far
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the midi program selector
`timescale 1ns/10ps
`default_nettype none
module tb;
   import mps_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, tx_byte, rx_byte;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic rready = 1'b0, awready, wready, bvalid, arready, rvalid, rx_valid;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic tx_valid, tx_ready, load_valid, knob_drv_valid, param_valid;
   logic pgm_up = 1'b0, pgm_dn = 1'b0, panel_chg = 1'b0;
   mps_ctl_t ctl_in = '0;
   mps_param_t panel_param = '0, param_out;
   mps_slot_t load_slot;
   logic [6:0] knob_drv_val, ctl_act_val;
   logic [3:0] ctl_act;
   logic [31:0] lq[$], cq[$], pq[$], xq[$], kq[$];
   integer num_errors = 0, comparisons = 0, seed = 7763, n, bank, eff, i;
   mps_top mps_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .ctl_in(ctl_in), .pgm_up(pgm_up),
      .pgm_dn(pgm_dn), .panel_chg(panel_chg), .panel_param(panel_param),
      .load_valid(load_valid), .load_slot(load_slot),
      .knob_drv_valid(knob_drv_valid), .knob_drv_val(knob_drv_val),
      .ctl_act(ctl_act), .ctl_act_val(ctl_act_val),
      .param_valid(param_valid), .param_out(param_out));
   mps_far mps_far_i (.aclk(aclk), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
   initial
   begin
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      if (aresetn === 1'b1 && load_valid === 1'b1)
         lq.push_back({20'h0, load_slot});
      if (aresetn === 1'b1 && ctl_act !== 4'h0)
         cq.push_back({21'h0, ctl_act, ctl_act_val});
      if (aresetn === 1'b1 && param_valid === 1'b1)
         pq.push_back({18'h0, param_out});
      if (aresetn === 1'b1 && knob_drv_valid === 1'b1)
         kq.push_back({25'h0, knob_drv_val});
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      chk(bresp, 2'b00);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      chk(rresp, er);
      chk(rdata, e);
   endtask
   // waits out the two-cycle answer, then checks the load count and the first load
   task automatic settle(input integer nl, input logic [31:0] e);
      repeat (6) @(posedge aclk);
      chk(lq.size(), nl);
      if (lq.size() > 0)
         chk(lq.pop_front(), e);
      lq.delete();
   endtask
   task automatic pc(input logic [7:0] st, input logic [7:0] d);
      mps_far_i.send(st);
      mps_far_i.send(d);
   endtask
   task automatic step(input logic up);
      @(posedge aclk);
      pgm_up <= up;
      pgm_dn <= !up;
      @(posedge aclk);
      pgm_up <= 1'b0;
      pgm_dn <= 1'b0;
   endtask
   task automatic txchk;
      for (i = 0; i < 300 && mps_far_i.rq.size() < xq.size(); i++)
         @(posedge aclk);
      chk(mps_far_i.rq.size(), xq.size());
      while (xq.size() > 0 && mps_far_i.rq.size() > 0)
         chk(mps_far_i.rq.pop_front(), xq.pop_front());
      xq.delete();
   endtask
   initial
   begin
      repeat (30000) @(posedge aclk);
      num_errors++;
      give_verdict();
   end
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_CFG, 32'h0000_0401, 2'b00);
      rd(ADDR_UNIT, 32'h0000_7F00, 2'b00);
      rd(8'h20, 32'h0, 2'b10);
      $display("test defaults done");
      bank = 0;
      repeat (4)
      begin
         n = {$random(seed)} % 50;
         eff = n;
         pc(8'hC0, n[7:0]);
         settle(1, {bank[5:0], eff[5:0]});
      end
      pc(8'hC0, 8'd50 + n[7:0]);
      settle(0, 0);
      pc(8'hC3, 8'h02);
      settle(0, 0);
      $display("test program change done");
      pc(8'hB0, 8'h00);
      mps_far_i.send(8'h06);
      pc(8'hC0, 8'h05);
      settle(1, {6'h06, 6'h05});
      pc(8'hB0, 8'h00);
      mps_far_i.send(8'h08);
      pc(8'hC0, 8'h31);
      settle(1, {6'h06, 6'h31});
      step(1'b0);
      settle(1, {6'h06, 6'h30});
      step(1'b1);
      settle(1, {6'h06, 6'h31});
      $display("test bank and step done");
      wr(ADDR_CFG, 32'h0000_0001);
      pc(8'hC0, 8'h03);
      settle(0, 0);
      step(1'b0);
      settle(1, {6'h06, 6'h30});
      wr(ADDR_CFG, 32'h0000_0402);
      pc(8'hC5, 8'h09);
      settle(1, {6'h06, 6'h09});
      wr(ADDR_CFG, 32'h0000_0400);
      pc(8'hC0, 8'h04);
      settle(0, 0);
      $display("test modes done");
      wr(ADDR_CFG, 32'h0000_3402);
      wr(ADDR_ASGN, 32'h0000_0007);
      n = {$random(seed)} % 128;
      @(posedge aclk);
      ctl_in.move <= 4'h1;
      ctl_in.val[0] <= n[6:0];
      @(posedge aclk);
      ctl_in.move <= 4'h0;
      xq = '{32'hB0, 32'h07, n[6:0]};
      txchk();
      pc(8'hB0, 8'h07);
      mps_far_i.send(8'h21);
      repeat (6) @(posedge aclk);
      chk(cq.size(), 1);
      if (cq.size() > 0)
         chk(cq.pop_front(), {21'h0, 4'h1, 7'h21});
      chk(kq.size(), 2);
      if (kq.size() == 2)
      begin
         chk(kq.pop_front(), n[6:0]);
         chk(kq.pop_front(), 7'h21);
      end
      kq.delete();
      wr(ADDR_ASGN, 32'h0000_0707);
      n = {$random(seed)} % 128;
      @(posedge aclk);
      ctl_in.move <= 4'h2;
      ctl_in.val[1] <= n[6:0];
      @(posedge aclk);
      ctl_in.move <= 4'h0;
      xq = '{32'hB0, 32'h07, n[6:0]};
      txchk();
      chk(kq.size(), 1);
      if (kq.size() > 0)
         chk(kq.pop_front(), n[6:0]);
      $display("test controllers done");
      // incoming sysex names own unit 0, then unit 3 which is dropped; automation uses the default destination
      xq.delete();
      pc(8'hF0, 8'h55);
      pc(8'h00, 8'h12);
      pc(8'h34, 8'hF7);
      pc(8'hF0, 8'h55);
      pc(8'h03, 8'h12);
      pc(8'h34, 8'hF7);
      repeat (6) @(posedge aclk);
      chk(pq.size(), 1);
      if (pq.size() > 0)
         chk(pq.pop_front(), {18'h0, 7'h12, 7'h34});
      chk(lq.size(), 0);
      @(posedge aclk);
      panel_param <= {7'h05, 7'h09};
      panel_chg <= 1'b1;
      @(posedge aclk);
      panel_chg <= 1'b0;
      xq = '{32'hF0, 32'h55, 32'h7F, 32'h05, 32'h09, 32'hF7};
      txchk();
      $display("test sysex done");
      wr(ADDR_CARD, 32'h0000_0001);
      pc(8'hB0, 8'h00);
      mps_far_i.send(8'h0D);
      pc(8'hC0, 8'h02);
      settle(1, {6'h0D, 6'h02});
      pc(8'hB0, 8'h00);
      mps_far_i.send(8'h0E);
      pc(8'hC0, 8'h02);
      settle(1, {6'h0D, 6'h02});
      $display("test card done");
      wr(ADDR_MAP, 32'h0000_870A);
      wr(ADDR_MAP, 32'h0000_EA0B);
      wr(ADDR_MAP, 32'h0000_030C);
      wr(ADDR_CHAIN, 32'h0000_4403);
      wr(ADDR_CHAIN, 32'h0001_7113);
      wr(ADDR_CFG, 32'h0000_3802);
      pc(8'hC0, 8'h0A);
      settle(1, 32'h087);
      step(1'b1);
      settle(1, 32'h0EA);
      wr(ADDR_CFG, 32'h0000_3C02);
      pc(8'hC0, 8'h0C);
      settle(1, 32'h044);
      step(1'b1);
      settle(1, 32'h171);
      $display("test map and chain done");
      give_verdict();
   end
endmodule // tb
`default_nettype wire
